//--- design/data_eeprom_access_control.sv
`default_nettype none

module data_eeprom_access_control
	import nv_access_pkg::*;
#(
	parameter int WRITE_LEN = WRITE_CYCLES,
	parameter int READ_LEN = READ_CYCLES
) (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic [7:0] mem_addr_i,
	input wire logic mem_indirect_i,
	input wire logic mem_wr_i,
	input wire logic mem_rd_i,
	input wire logic [7:0] mem_wdata_i,
	input wire logic global_irq_enable_i,
	input wire logic stack_full_i,
	input wire logic irq_ack_i,
	output logic [7:0] mem_rdata_o,
	output logic irq_vector_o,
	output logic busy_o
);

	function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] offset);
		addr_hit = (addr == offset);
	endfunction : addr_hit

	function automatic logic [CNT_W-1:0] len_to_cnt(input int len);
		len_to_cnt = CNT_W'(len - 1);
	endfunction : len_to_cnt

	// register state
	logic write_arm_q;
	logic write_trig_q;
	logic read_arm_q;
	logic read_trig_q;
	logic [5:0] index_q;
	logic [7:0] byte_q;
	logic bank_q;
	logic nv_irq_en_q;
	logic mf_irq_en_q;
	logic nv_irq_flag_q;
	logic mf_irq_flag_q;
	nv_state_t state_q;
	nv_state_t state_d;
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;
	logic [5:0] op_addr_q;
	logic [7:0] op_data_q;

	// store port
	logic [7:0] store_rdata;

	// decode
	wire bank1_sel = mem_indirect_i & bank_q;
	wire hit_ctrl = bank1_sel & addr_hit(mem_addr_i, CTRL_OFFSET);
	wire hit_index = addr_hit(mem_addr_i, INDEX_OFFSET);
	wire hit_byte = addr_hit(mem_addr_i, BYTE_OFFSET);
	wire hit_bank = addr_hit(mem_addr_i, BANK_OFFSET);
	wire hit_irq = addr_hit(mem_addr_i, IRQ_OFFSET);
	wire wr_ctrl = mem_wr_i & hit_ctrl;
	wire wr_index = mem_wr_i & hit_index;
	wire wr_byte = mem_wr_i & hit_byte;
	wire wr_bank = mem_wr_i & hit_bank;
	wire wr_irq = mem_wr_i & hit_irq;

	// trigger handling
	wire idle = (state_q == ST_IDLE);
	wire new_write_trig = mem_wdata_i[CTRL_WRITE_TRIG_BIT];
	wire new_read_trig = mem_wdata_i[CTRL_READ_TRIG_BIT];
	wire both_trig = new_write_trig & new_read_trig;
	wire start_write = wr_ctrl & new_write_trig & ~both_trig & write_arm_q & idle;
	wire start_read = wr_ctrl & new_read_trig & ~both_trig & read_arm_q & idle;
	wire cnt_zero = (cnt_q == '0);
	wire write_done = (state_q == ST_WRITE) & cnt_zero;
	wire read_done = (state_q == ST_READ) & cnt_zero;
	wire store_we = write_done & write_arm_q;
	wire store_re = start_read;

	// read mux
	wire [7:0] ctrl_view = {4'h0, write_arm_q, write_trig_q, read_arm_q, read_trig_q};
	wire [7:0] index_view = {2'b00, index_q};
	wire [7:0] bank_view = {7'h00, bank_q};
	wire [7:0] irq_view = {4'h0, mf_irq_flag_q, nv_irq_flag_q, mf_irq_en_q, nv_irq_en_q};
	wire [7:0] read_mux = hit_ctrl ? ctrl_view :
		hit_index ? index_view :
		hit_byte ? byte_q :
		hit_bank ? bank_view :
		hit_irq ? irq_view : 8'h00;

	// interrupt gating
	wire vector_d = global_irq_enable_i & ~stack_full_i & nv_irq_en_q & mf_irq_en_q
		& mf_irq_flag_q;
	wire mf_flag_clr = irq_ack_i | (wr_irq & ~mem_wdata_i[IRQ_MF_FLAG_BIT]);
	wire nv_flag_clr = wr_irq & ~mem_wdata_i[IRQ_NV_FLAG_BIT];
	wire mf_flag_set = write_done | (wr_irq & mem_wdata_i[IRQ_MF_FLAG_BIT]);
	wire nv_flag_set = write_done | (wr_irq & mem_wdata_i[IRQ_NV_FLAG_BIT]);

	// sequencer next state
	always_comb
	begin
		state_d = state_q;
		cnt_d = cnt_q;
		case (state_q)
			ST_IDLE:
			begin
				if (start_write)
				begin
					state_d = ST_WRITE;
					cnt_d = len_to_cnt(WRITE_LEN);
				end
				else if (start_read)
				begin
					state_d = ST_READ;
					cnt_d = len_to_cnt(READ_LEN);
				end
			end
			ST_READ, ST_WRITE:
			begin
				if (cnt_zero)
				begin
					state_d = ST_IDLE;
				end
				else
				begin
					cnt_d = cnt_q - 1'b1;
				end
			end
			default:
			begin
				state_d = ST_IDLE;
				cnt_d = '0;
			end
		endcase
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
		begin
			state_q <= ST_IDLE;
			cnt_q <= '0;
		end
		else if (ce_i)
		begin
			state_q <= state_d;
			cnt_q <= cnt_d;
		end
	end

	// control register
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
		begin
			write_arm_q <= 1'b0;
			read_arm_q <= 1'b0;
		end
		else if (ce_i && wr_ctrl)
		begin
			write_arm_q <= mem_wdata_i[CTRL_WRITE_ARM_BIT];
			read_arm_q <= mem_wdata_i[CTRL_READ_ARM_BIT];
		end
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
		begin
			write_trig_q <= 1'b0;
			read_trig_q <= 1'b0;
		end
		else if (ce_i)
		begin
			write_trig_q <= start_write | (write_trig_q & ~write_done);
			read_trig_q <= start_read | (read_trig_q & ~read_done);
		end
	end

	// index, bank and byte registers
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
		begin
			index_q <= INDEX_RESET;
			bank_q <= 1'b0;
		end
		else if (ce_i)
		begin
			if (wr_index)
			begin
				index_q <= mem_wdata_i[5:0];
			end
			if (wr_bank)
			begin
				bank_q <= mem_wdata_i[BANK_SEL_BIT];
			end
		end
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
		begin
			byte_q <= BYTE_RESET;
		end
		else if (ce_i)
		begin
			if (read_done)
			begin
				byte_q <= store_rdata;
			end
			else if (wr_byte)
			begin
				byte_q <= mem_wdata_i;
			end
		end
	end

	// write payload captured at trigger
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
		begin
			op_addr_q <= INDEX_RESET;
			op_data_q <= BYTE_RESET;
		end
		else if (ce_i && start_write)
		begin
			op_addr_q <= index_q;
			op_data_q <= byte_q;
		end
	end

	// interrupt enables and flags, set wins
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
		begin
			nv_irq_en_q <= 1'b0;
			mf_irq_en_q <= 1'b0;
			nv_irq_flag_q <= 1'b0;
			mf_irq_flag_q <= 1'b0;
		end
		else if (ce_i)
		begin
			if (wr_irq)
			begin
				nv_irq_en_q <= mem_wdata_i[IRQ_NV_EN_BIT];
				mf_irq_en_q <= mem_wdata_i[IRQ_MF_EN_BIT];
			end
			nv_irq_flag_q <= nv_flag_set | (nv_irq_flag_q & ~nv_flag_clr);
			mf_irq_flag_q <= mf_flag_set | (mf_irq_flag_q & ~mf_flag_clr);
		end
	end

	// outputs
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
		begin
			mem_rdata_o <= RDATA_RESET;
			irq_vector_o <= 1'b0;
			busy_o <= 1'b0;
		end
		else if (ce_i)
		begin
			if (mem_rd_i)
			begin
				mem_rdata_o <= read_mux;
			end
			irq_vector_o <= vector_d;
			busy_o <= (state_d != ST_IDLE);
		end
	end

	// byte store
	nv_store_mem #(
		.DEPTH(NV_DEPTH),
		.AW(NV_AW),
		.DW(NV_DW)
	) u_store (
		.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n_i),
		.ce_i(ce_i),
		.we_i(store_we),
		.waddr_i(op_addr_q),
		.wdata_i(op_data_q),
		.re_i(store_re),
		.raddr_i(index_q),
		.rdata_o(store_rdata)
	);

	// checking helpers
	logic [CNT_W-1:0] wlen_q;
	logic [CNT_W-1:0] rlen_q;

	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
		begin
			wlen_q <= '0;
			rlen_q <= '0;
		end
		else if (ce_i)
		begin
			wlen_q <= write_trig_q ? wlen_q + 1'b1 : '0;
			rlen_q <= read_trig_q ? rlen_q + 1'b1 : '0;
		end
	end

	default clocking cb @(posedge ref_clk_i);
	endclocking

	default disable iff (!rst_n_i);

	chk_write_arm_gate: assert property ($rose(write_trig_q) |-> $past(write_arm_q))
		else $error("write started without write arm");

	chk_read_arm_gate: assert property ($rose(read_trig_q) |-> $past(read_arm_q))
		else $error("read started without read arm");

	chk_write_len: assert property ($fell(write_trig_q) |-> wlen_q == CNT_W'(WRITE_LEN))
		else $error("write trigger held wrong number of cycles");

	chk_read_len: assert property ($fell(read_trig_q) |-> rlen_q == CNT_W'(READ_LEN))
		else $error("read trigger held wrong number of cycles");

	chk_no_dual_trig: assert property (!(write_trig_q && read_trig_q))
		else $error("read and write cycles overlap");

	chk_index_view: assert property ((ce_i && mem_rd_i && hit_index)
		|=> mem_rdata_o == {2'b00, $past(index_q)})
		else $error("index readback wrong");

	chk_ctrl_bank: assert property ((ce_i && mem_rd_i && !bank1_sel
		&& addr_hit(mem_addr_i, CTRL_OFFSET)) |=> mem_rdata_o == 8'h00)
		else $error("control register visible outside bank 1");

	chk_flags_on_end: assert property ((ce_i && write_done)
		|=> nv_irq_flag_q && mf_irq_flag_q && !write_trig_q)
		else $error("write end did not raise flags");

	chk_vector_gate: assert property ((ce_i && !(global_irq_enable_i && !stack_full_i
		&& nv_irq_en_q && mf_irq_en_q)) |=> !irq_vector_o)
		else $error("vector raised with an enable missing");

	chk_fetch_hold: assert property ((ce_i && read_done)
		|=> byte_q == $past(store_rdata) && !read_trig_q)
		else $error("fetched byte not loaded");

	chk_payload_kept: assert property ((ce_i && start_write)
		|=> op_data_q == $past(byte_q) && op_addr_q == $past(index_q))
		else $error("write payload not captured");

	chk_arm_blocks: assert property (store_we |-> write_arm_q && state_q == ST_WRITE)
		else $error("store written without write arm");

	cov_write_done: cover property (ce_i && store_we);
	cov_read_done: cover property (ce_i && read_done);
	cov_vector: cover property ($rose(irq_vector_o));
	cov_dual_trig: cover property (ce_i && wr_ctrl && both_trig);

endmodule : data_eeprom_access_control

`default_nettype wire

//--- design/nv_access_pkg.sv
// Contract
// - store holds 64 locations of 8 bits, reached only through three registers.
// - each read or write moves one byte at the indexed location.
// - control register sits only at 40H of bank 1, via indirect port.
// - index and byte registers answer in every bank.
// - index holds 6 bits; bits 7 and 6 read zero.
// - write arm low blocks every store write.
// - write trigger starts a write only if write arm already set.
// - hardware clears write trigger when the write cycle ends.
// - read arm low blocks every store read.
// - read trigger starts a read only if read arm already set.
// - hardware clears read trigger when the read cycle ends.
// - byte register keeps fetched byte until next read or write.
// - write cycle timed independently of the system clock; here it is counted as WRITE_LEN cycles of ref_clk_i, paused while ce_i is low.
// - reset clears write arm and selects bank 0.
// - completion interrupt needs block enable and shared enable both set.
// - write end sets block flag and shared request flag.
// - vector only with global, block, shared enables set and stack not full.
// - service clears only shared flag; software clears block flag.
// - bank select bit 0 picks bank for indirect access; direct is bank 0.
`default_nettype none

package nv_access_pkg;

	localparam int NV_DEPTH = 64;
	localparam int NV_AW = 6;
	localparam int NV_DW = 8;

	localparam logic [7:0] CTRL_OFFSET = 8'h40;
	localparam logic [7:0] INDEX_OFFSET = 8'h1e;
	localparam logic [7:0] BYTE_OFFSET = 8'h1f;
	localparam logic [7:0] BANK_OFFSET = 8'h04;
	localparam logic [7:0] IRQ_OFFSET = 8'h0e;

	localparam int CTRL_WRITE_ARM_BIT = 3;
	localparam int CTRL_WRITE_TRIG_BIT = 2;
	localparam int CTRL_READ_ARM_BIT = 1;
	localparam int CTRL_READ_TRIG_BIT = 0;
	localparam int BANK_SEL_BIT = 0;
	localparam int IRQ_NV_EN_BIT = 0;
	localparam int IRQ_MF_EN_BIT = 1;
	localparam int IRQ_NV_FLAG_BIT = 2;
	localparam int IRQ_MF_FLAG_BIT = 3;

	localparam logic [5:0] INDEX_RESET = 6'h00;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic [7:0] RDATA_RESET = 8'h00;

	localparam int CLK_PERIOD_NS = 5;
	localparam int WRITE_TIME_NS = 2000;
	localparam int READ_TIME_NS = 20;
	localparam int WRITE_CYCLES = (WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int READ_CYCLES = (READ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 16;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_READ,
		ST_WRITE
	} nv_state_t;

endpackage : nv_access_pkg

`default_nettype wire

//--- design/nv_store_mem.sv
`default_nettype none

module nv_store_mem
	import nv_access_pkg::*;
#(
	parameter int DEPTH = NV_DEPTH,
	parameter int AW = NV_AW,
	parameter int DW = NV_DW
) (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic we_i,
	input wire logic [AW-1:0] waddr_i,
	input wire logic [DW-1:0] wdata_i,
	input wire logic re_i,
	input wire logic [AW-1:0] raddr_i,
	output logic [DW-1:0] rdata_o
);

	logic [DW-1:0] cells [DEPTH];

	// cell array, no reset
	always_ff @(posedge ref_clk_i)
	begin
		if (ce_i && we_i)
		begin
			cells[waddr_i] <= wdata_i;
		end
	end

	// registered read port
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
		begin
			rdata_o <= DW'(RDATA_RESET);
		end
		else if (ce_i && re_i)
		begin
			rdata_o <= cells[raddr_i];
		end
	end

endmodule : nv_store_mem

`default_nettype wire

//--- test/tb_top.sv
`default_nettype none

module tb_top
	import nv_access_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int WR_LEN = 20;
	localparam int RD_LEN = 6;

	logic ref_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic ce_i = 1'b1;
	logic [7:0] mem_addr_i = 8'h00;
	logic mem_indirect_i = 1'b0;
	logic mem_wr_i = 1'b0;
	logic mem_rd_i = 1'b0;
	logic [7:0] mem_wdata_i = 8'h00;
	logic global_irq_enable_i = 1'b1;
	logic stack_full_i = 1'b0;
	logic irq_ack_i = 1'b0;
	logic [7:0] mem_rdata_o;
	logic irq_vector_o;
	logic busy_o;
	int error_cnt = 0;
	int tests_run = 0;
	int cyc = 0;
	int n;

	data_eeprom_access_control #(
		.WRITE_LEN(WR_LEN),
		.READ_LEN(RD_LEN)
	) u_dut (
		.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n_i),
		.ce_i(ce_i),
		.mem_addr_i(mem_addr_i),
		.mem_indirect_i(mem_indirect_i),
		.mem_wr_i(mem_wr_i),
		.mem_rd_i(mem_rd_i),
		.mem_wdata_i(mem_wdata_i),
		.global_irq_enable_i(global_irq_enable_i),
		.stack_full_i(stack_full_i),
		.irq_ack_i(irq_ack_i),
		.mem_rdata_o(mem_rdata_o),
		.irq_vector_o(irq_vector_o),
		.busy_o(busy_o)
	);

	always #2.5 ref_clk_i = ~ref_clk_i;

	task automatic report_and_stop();
		$display("errors %0d checks %0d", error_cnt, tests_run);
		if (error_cnt == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : report_and_stop

	// cycle ceiling against hangs
	always @(posedge ref_clk_i)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			error_cnt++;
			report_and_stop();
		end
	end

	task automatic chk8(input string nm, input logic [7:0] exp, input logic [7:0] got);
		tests_run++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("unexpected %s: expected %h seen %h", nm, exp, got);
		end
	endtask : chk8

	task automatic chk1(input string nm, input logic exp, input logic got);
		tests_run++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("unexpected %s: expected %b seen %b", nm, exp, got);
		end
	endtask : chk1

	task automatic wr(input logic [7:0] a, input logic ind, input logic [7:0] d);
		@(posedge ref_clk_i);
		mem_addr_i <= a;
		mem_indirect_i <= ind;
		mem_wdata_i <= d;
		mem_wr_i <= 1'b1;
		@(posedge ref_clk_i);
		mem_wr_i <= 1'b0;
		#1;
	endtask : wr

	task automatic rdc(input logic [7:0] a, input logic ind, input logic [7:0] e, input string nm);
		@(posedge ref_clk_i);
		mem_addr_i <= a;
		mem_indirect_i <= ind;
		mem_rd_i <= 1'b1;
		@(posedge ref_clk_i);
		mem_rd_i <= 1'b0;
		#1;
		chk8(nm, e, mem_rdata_o);
	endtask : rdc

	task automatic wc(input logic [7:0] d);
		wr(CTRL_OFFSET, 1'b1, d);
	endtask : wc

	task automatic rc(input logic [7:0] e);
		rdc(CTRL_OFFSET, 1'b1, e, "nv_control");
	endtask : rc

	// counts cycles until busy drops
	task automatic wait_idle(output int c);
		c = 0;
		while (busy_o !== 1'b0 && c < 1000)
		begin
			@(posedge ref_clk_i);
			#1;
			c++;
		end
	endtask : wait_idle

	task automatic do_write(input logic [7:0] idx, input logic [7:0] dat);
		logic gie;
		gie = global_irq_enable_i;
		wr(INDEX_OFFSET, 1'b0, idx);
		wr(BYTE_OFFSET, 1'b0, dat);
		global_irq_enable_i <= 1'b0;
		wc(8'h08);
		wc(8'h0c);
		global_irq_enable_i <= gie;
		wait_idle(n);
		chk8("write cycles", 8'(WR_LEN), 8'(n));
	endtask : do_write

	task automatic read_back(input logic [7:0] idx, input logic [7:0] dat);
		wr(INDEX_OFFSET, 1'b0, idx);
		wc(8'h02);
		wc(8'h03);
		rc(8'h03);
		wait_idle(n);
		// the control read above used two of the read cycles
		chk8("read cycles", 8'(RD_LEN - 2), 8'(n));
		rc(8'h02);
		rdc(BYTE_OFFSET, 1'b0, dat, "fetched byte");
		rdc(BYTE_OFFSET, 1'b1, dat, "held byte");
	endtask : read_back

	task automatic t_reset();
		chk1("busy", 1'b0, busy_o);
		chk1("vector", 1'b0, irq_vector_o);
		rdc(INDEX_OFFSET, 1'b0, 8'h00, "index reset");
		rdc(BYTE_OFFSET, 1'b0, 8'h00, "byte reset");
		rdc(BANK_OFFSET, 1'b0, 8'h00, "bank reset");
		rdc(IRQ_OFFSET, 1'b0, 8'h00, "irq reset");
		wr(BANK_OFFSET, 1'b0, 8'h01);
		rc(8'h00);
	endtask : t_reset

	task automatic t_regs();
		wr(INDEX_OFFSET, 1'b0, 8'hff);
		rdc(INDEX_OFFSET, 1'b0, 8'h3f, "index width");
		wr(BYTE_OFFSET, 1'b1, 8'ha5);
		rdc(BYTE_OFFSET, 1'b0, 8'ha5, "byte in bank 1");
		rdc(INDEX_OFFSET, 1'b1, 8'h3f, "index in bank 1");
		wc(8'h0a);
		rdc(CTRL_OFFSET, 1'b0, 8'h00, "direct control");
		wr(BANK_OFFSET, 1'b0, 8'h00);
		rdc(CTRL_OFFSET, 1'b1, 8'h00, "bank 0 control");
		wr(BANK_OFFSET, 1'b0, 8'h01);
		rc(8'h0a);
		wc(8'h0f);
		rc(8'h0a);
		chk1("busy both", 1'b0, busy_o);
		wc(8'h00);
		wc(8'h04);
		rc(8'h00);
		chk1("busy no arm", 1'b0, busy_o);
		wc(8'h01);
		rc(8'h00);
		chk1("busy no read arm", 1'b0, busy_o);
	endtask : t_regs

	task automatic t_write();
		wr(INDEX_OFFSET, 1'b0, 8'h05);
		wr(BYTE_OFFSET, 1'b0, 8'h3c);
		wc(8'h08);
		wc(8'h0c);
		rc(8'h0c);
		wr(BYTE_OFFSET, 1'b0, 8'h77);
		wr(INDEX_OFFSET, 1'b0, 8'h06);
		wait_idle(n);
		rc(8'h08);
		read_back(8'h05, 8'h3c);
		do_write(8'h3f, 8'h96);
		read_back(8'h3f, 8'h96);
		// arm dropped mid-cycle leaves the cell alone
		wr(INDEX_OFFSET, 1'b0, 8'h05);
		wc(8'h08);
		wc(8'h0c);
		wc(8'h04);
		wait_idle(n);
		read_back(8'h05, 8'h3c);
	endtask : t_write

	// clock enable low: no access taken, read data held
	task automatic t_hold();
		ce_i <= 1'b0;
		wc(8'h0a);
		rdc(BYTE_OFFSET, 1'b0, 8'h3c, "frozen read data");
		ce_i <= 1'b1;
		rc(8'h02);
	endtask : t_hold

	task automatic t_irq();
		wr(IRQ_OFFSET, 1'b0, 8'h03);
		do_write(8'h10, 8'h42);
		@(posedge ref_clk_i);
		#1;
		chk1("vector", 1'b1, irq_vector_o);
		rdc(IRQ_OFFSET, 1'b0, 8'h0f, "irq flags");
		stack_full_i <= 1'b1;
		@(posedge ref_clk_i);
		@(posedge ref_clk_i);
		#1;
		chk1("vector stack full", 1'b0, irq_vector_o);
		stack_full_i <= 1'b0;
		irq_ack_i <= 1'b1;
		@(posedge ref_clk_i);
		irq_ack_i <= 1'b0;
		rdc(IRQ_OFFSET, 1'b0, 8'h07, "irq after ack");
		chk1("vector after ack", 1'b0, irq_vector_o);
		wr(IRQ_OFFSET, 1'b0, 8'h01);
		do_write(8'h11, 8'h24);
		@(posedge ref_clk_i);
		#1;
		chk1("vector shared off", 1'b0, irq_vector_o);
		rdc(IRQ_OFFSET, 1'b0, 8'h0d, "flags shared off");
		global_irq_enable_i <= 1'b0;
		wr(IRQ_OFFSET, 1'b0, 8'h03);
		do_write(8'h12, 8'h81);
		@(posedge ref_clk_i);
		#1;
		chk1("vector global off", 1'b0, irq_vector_o);
		read_back(8'h10, 8'h42);
	endtask : t_irq

	initial
	begin
		repeat (8) @(posedge ref_clk_i);
		rst_n_i <= 1'b1;
		@(posedge ref_clk_i);
		#1;
		t_reset();
		t_regs();
		t_write();
		t_hold();
		t_irq();
		report_and_stop();
	end

endmodule : tb_top

`default_nettype wire
